/* shared/fsp_pkg.sv */
/*
  Constants, field layout, command codes and timing for the flash
  self-programming controller.
  Assumes a 200 MHz system clock and a byte-addressed Avalon-MM register bus.
*/
package fsp_pkg;

  // Register map: the register offset is a word index, byte address is index * 4
  localparam logic [7:0] CSR_INDEX = 8'h37;
  localparam logic [7:0] CFG_INDEX = 8'h38;
  localparam logic [9:0] CSR_ADDR  = {CSR_INDEX, 2'b00};
  localparam logic [9:0] CFG_ADDR  = {CFG_INDEX, 2'b00};

  // Control/status fields
  localparam int BIT_IRQ_EN  = 7;
  localparam int BIT_BUSY    = 6;
  localparam int BIT_RSV     = 5;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // Command patterns of the low five bits; all but CMD_NONE are legal
  localparam logic [4:0] CMD_NONE   = 5'h00;
  localparam logic [4:0] CMD_REEN   = 5'h11;
  localparam logic [4:0] CMD_LOCK   = 5'h09;
  localparam logic [4:0] CMD_WRITE  = 5'h05;
  localparam logic [4:0] CMD_ERASE  = 5'h03;
  localparam logic [4:0] CMD_FILL   = 5'h01;

  // Arming window: four cycles; lock/fuse readback within three
  localparam logic [1:0] ARM_LAST   = 2'h3;
  localparam logic [1:0] LPM_LIMIT  = 2'h3;

  // Flash geometry
  localparam int         PAGE_W      = 7;
  localparam int         WORD_W      = 6;
  localparam int         PC_W        = 13;
  localparam int         Z_PAGE_LSB  = 7;
  localparam int         Z_PAGE_MSB  = 13;
  localparam int         Z_WORD_LSB  = 1;
  localparam int         Z_WORD_MSB  = 6;
  localparam int         PAGE_WORDS  = 64;
  localparam logic [6:0] CONC_PAGES  = 7'h70;
  localparam logic [7:0] LOCK_RESET  = 8'hff;

  // Boot section starts by fuse setting, all ending at the top word
  localparam logic [12:0] BOOT_END    = 13'h1fff;
  localparam logic [12:0] BOOT_ST_128 = 13'h1f80;
  localparam logic [12:0] BOOT_ST_256 = 13'h1f00;
  localparam logic [12:0] BOOT_ST_512 = 13'h1e00;
  localparam logic [12:0] BOOT_ST_1K  = 13'h1c00;

  // Programming time
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int PROG_MIN_US     = 3700;
  localparam int PROG_MAX_US     = 4500;
  localparam int PROG_MIN_CYCLES = (PROG_MIN_US * 1000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000);
  localparam int PROG_MAX_CYCLES = (PROG_MAX_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int OP_CNT_W        = 20;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_OP
  } fsp_state_t;

endpackage

/* verilog/fsp_ctrl.sv */
/*
  Flash self-programming controller: control/status register, arming window,
  temporary page buffer, page erase/write and lock-bit timing, region busy and halt.
  Assumes the core drives store/load requests as one-cycle pulses synchronous
  to clk_sys_i, and a flash macro that performs the erase/write it is told.
*/
// Added by the designer: the Avalon-MM slave port.
module fsp_ctrl #(
  parameter int PROG_CYCLES = fsp_pkg::PROG_MIN_CYCLES
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rstn_i,
  // Avalon-MM slave
  input  wire logic [9:0]                  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // Core side
  input  wire logic                        spm_req_i,
  input  wire logic                        lpm_req_i,
  input  wire logic [15:0]                 z_ptr_i,
  input  wire logic [7:0]                  r0_i,
  input  wire logic [7:0]                  r1_i,
  input  wire logic                        gie_i,
  input  wire logic [1:0]                  boot_size_select_i,
  input  wire logic [7:0]                  fuse_bits_i,
  output logic                             ready_irq_o,
  output logic                             cpu_halt_o,
  output logic                             region_blocked_o,
  output logic                             lpm_valid_o,
  output logic      [7:0]                  lpm_data_o,
  output logic      [fsp_pkg::PC_W-1:0]    boot_start_o,
  output logic      [7:0]                  lock_bits_o,
  // Flash macro side
  output logic                             prog_start_o,
  output logic                             prog_erase_o,
  output logic      [fsp_pkg::PAGE_W-1:0]  prog_page_o,
  output logic                             prog_done_o,
  input  wire logic [fsp_pkg::WORD_W-1:0]  prog_buf_idx_i,
  output logic      [15:0]                 prog_buf_data_o
);
  import fsp_pkg::*;

  fsp_state_t                state_q;
  logic                      wait_q;
  logic [31:0]               rdata_q;
  logic                      irq_en_q;
  logic                      busy_q;
  logic [4:0]                cmd_q;
  logic [1:0]                arm_cnt_q;
  logic [OP_CNT_W-1:0]       op_cnt_q;
  logic                      halt_q;
  logic                      irq_q;
  logic                      lpm_valid_q;
  logic [7:0]                lpm_data_q;
  logic [7:0]                lock_q;
  logic [1:0]                boot_sz_q;
  logic                      strap_taken_q;
  logic [PC_W-1:0]           boot_start_q;
  logic                      prog_start_q;
  logic                      prog_erase_q;
  logic [PAGE_W-1:0]         prog_page_q;
  logic                      prog_done_q;
  logic [15:0]               prog_data_q;
  logic [15:0]               buf_q [PAGE_WORDS];
  logic [PAGE_WORDS-1:0]     buf_valid_q;
  logic                      wr_acc;
  logic                      wr_legal;
  logic                      arm_wr;
  logic                      store;
  logic                      is_op_cmd;
  logic                      stall_pg;
  logic                      op_done;
  logic                      window_end;
  logic [PAGE_W-1:0]         z_page;
  logic [WORD_W-1:0]         z_word;
  logic [4:0]                wr_low;

  // Pointer decode; bits 15:14 and bit 0 are not used for stores
  assign z_page   = z_ptr_i[Z_PAGE_MSB:Z_PAGE_LSB];
  assign z_word   = z_ptr_i[Z_WORD_MSB:Z_WORD_LSB];
  assign stall_pg = (z_page >= CONC_PAGES);

  // Bus write decode and command legality
  assign wr_acc   = avs_write_i && !wait_q && (avs_address_i == CSR_ADDR) && avs_byteenable_i[0];
  assign wr_low   = avs_writedata_i[4:0];
  assign wr_legal = (wr_low == CMD_REEN) || (wr_low == CMD_LOCK) || (wr_low == CMD_WRITE) ||
                    (wr_low == CMD_ERASE) || (wr_low == CMD_FILL);
  assign arm_wr   = wr_acc && wr_legal && (state_q != ST_OP);

  // Store and operation events
  assign store      = spm_req_i && (state_q == ST_ARMED) && !arm_wr;
  assign is_op_cmd  = (cmd_q == CMD_ERASE) || (cmd_q == CMD_WRITE) || (cmd_q == CMD_LOCK);
  assign window_end = (state_q == ST_ARMED) && (arm_cnt_q == ARM_LAST) && !store && !arm_wr;
  assign op_done    = (state_q == ST_OP) && (op_cnt_q == OP_CNT_W'(PROG_CYCLES - 1));

  // Bus handshake: one wait cycle, then an accepting edge with waitrequest low
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
    end
  end

  // Read data is captured so it stands at the accepting edge
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      if (avs_address_i == CSR_ADDR) begin
        rdata_q <= {24'h00_0000, irq_en_q, busy_q, 1'b0, cmd_q};
      end else if (avs_address_i == CFG_ADDR) begin
        rdata_q <= {24'h00_0000, 4'h0, halt_q, (state_q == ST_OP), boot_sz_q};
      end else begin
        rdata_q <= 32'h0000_0000;                                  // Unmapped reads zero
      end
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
    end else if (arm_wr) begin
      state_q <= ST_ARMED;
    end else begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ARMED: begin
          if (store) begin
            state_q <= is_op_cmd ? ST_OP : ST_IDLE;
          end else if (arm_cnt_q == ARM_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_OP: begin
          if (op_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Arming window counter, restarted by every legal write outside an operation
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      arm_cnt_q <= 2'h0;
    end else if (arm_wr) begin
      arm_cnt_q <= 2'h0;
    end else if (state_q == ST_ARMED && arm_cnt_q != ARM_LAST) begin
      arm_cnt_q <= arm_cnt_q + 2'h1;
    end
  end

  // Operation timer
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      op_cnt_q <= '0;
    end else if (store) begin
      op_cnt_q <= '0;
    end else if (state_q == ST_OP) begin
      op_cnt_q <= op_cnt_q + OP_CNT_W'(1);
    end
  end

  // Command bits: armed by a legal write, cleared on a fill or re-enable store, timeout or completion
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cmd_q <= CSR_RESET[4:0];
    end else if (arm_wr) begin
      cmd_q <= wr_low;
    end else if (store && !is_op_cmd) begin
      cmd_q <= CMD_NONE;
    end else if (window_end || op_done) begin
      cmd_q <= CMD_NONE;
    end
  end

  // Interrupt enable bit is a plain read/write bit
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_en_q <= CSR_RESET[BIT_IRQ_EN];
    end else if (wr_acc) begin
      irq_en_q <= avs_writedata_i[BIT_IRQ_EN];
    end
  end

  // Read-region busy flag
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      busy_q <= CSR_RESET[BIT_BUSY];
    end else if (store && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE) && !stall_pg) begin
      busy_q <= 1'b1;
    end else if (store && (cmd_q == CMD_FILL || cmd_q == CMD_REEN)) begin
      busy_q <= 1'b0;
    end
  end

  // Core halt for operations on the stalling region
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      halt_q <= 1'b0;
    end else if (store && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE) && stall_pg) begin
      halt_q <= 1'b1;
    end else if (op_done) begin
      halt_q <= 1'b0;
    end
  end

  // Temporary page buffer data
  always_ff @(posedge clk_sys_i) begin
    if (store && cmd_q == CMD_FILL) begin
      buf_q[z_word] <= {r1_i, r0_i};
    end
    prog_data_q <= buf_q[prog_buf_idx_i];
  end

  // Buffer occupancy: a re-enable write during loading discards the data
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      buf_valid_q <= '0;
    end else if (store && cmd_q == CMD_FILL) begin
      buf_valid_q[z_word] <= 1'b1;
    end else if (arm_wr && wr_low == CMD_REEN && |buf_valid_q) begin
      buf_valid_q <= '0;
    end else if (op_done && cmd_q == CMD_WRITE) begin
      buf_valid_q <= '0;
    end
  end

  // Flash macro command outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prog_start_q <= 1'b0;
      prog_erase_q <= 1'b0;
      prog_page_q  <= '0;
      prog_done_q  <= 1'b0;
    end else begin
      prog_start_q <= store && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE);
      prog_done_q  <= op_done && cmd_q != CMD_LOCK;
      if (store && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE)) begin
        prog_erase_q <= (cmd_q == CMD_ERASE);
        prog_page_q  <= z_page;
      end
    end
  end

  // Lock bits programmed from R0 only
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lock_q <= LOCK_RESET;
    end else if (store && cmd_q == CMD_LOCK) begin
      lock_q <= r0_i;
    end
  end

  // Program-load readback of lock or fuse byte
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lpm_valid_q <= 1'b0;
      lpm_data_q  <= 8'h00;
    end else begin
      lpm_valid_q <= lpm_req_i;
      if (lpm_req_i) begin
        if (state_q == ST_ARMED && cmd_q == CMD_LOCK && arm_cnt_q < LPM_LIMIT) begin
          lpm_data_q <= z_ptr_i[0] ? fuse_bits_i : lock_q;
        end else begin
          lpm_data_q <= 8'h00;
        end
      end
    end
  end

  // Ready interrupt request
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en_q && gie_i && !cmd_q[0];
    end
  end

  // Boot size strap taken once after reset release
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      strap_taken_q <= 1'b0;
      boot_sz_q     <= 2'h0;
      boot_start_q  <= BOOT_ST_1K;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      boot_sz_q     <= boot_size_select_i;
      unique case (boot_size_select_i)
        2'h3: boot_start_q <= BOOT_ST_128;
        2'h2: boot_start_q <= BOOT_ST_256;
        2'h1: boot_start_q <= BOOT_ST_512;
        2'h0: boot_start_q <= BOOT_ST_1K;
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign ready_irq_o       = irq_q;
  assign cpu_halt_o        = halt_q;
  assign region_blocked_o  = busy_q;
  assign lpm_valid_o       = lpm_valid_q;
  assign lpm_data_o        = lpm_data_q;
  assign boot_start_o      = boot_start_q;
  assign lock_bits_o       = lock_q;
  assign prog_start_o      = prog_start_q;
  assign prog_erase_o      = prog_erase_q;
  assign prog_page_o       = prog_page_q;
  assign prog_done_o       = prog_done_q;
  assign prog_buf_data_o   = prog_data_q;

  // Checks
  property p_rsv_zero;
    @(posedge clk_sys_i) disable iff (!rstn_i) !avs_waitrequest_o |-> avs_readdata_o[BIT_RSV] == 1'b0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit read as one");
  property p_irq;
    @(posedge clk_sys_i) disable iff (!rstn_i) ##1 ready_irq_o == $past(irq_en_q && gie_i && !cmd_q[0]);
  endproperty
  a_irq: assert property (p_irq) else $error("ready interrupt wrong");
  property p_busy_set;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      store && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE) && !stall_pg |=> busy_q && !cpu_halt_o;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy flag not set");
  property p_fill_clear;
    @(posedge clk_sys_i) disable iff (!rstn_i) store && cmd_q == CMD_FILL |=> !busy_q && cmd_q == CMD_NONE;
  endproperty
  a_fill_clear: assert property (p_fill_clear) else $error("buffer load did not clear busy");
  property p_halt;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      store && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE) && stall_pg |=> cpu_halt_o throughout (state_q == ST_OP)[*8];
  endproperty
  a_halt: assert property (p_halt) else $error("core not halted");
  property p_window;
    @(posedge clk_sys_i) disable iff (!rstn_i) arm_wr ##1 (!spm_req_i && !wr_acc)[*4] |=> cmd_q == CMD_NONE;
  endproperty
  a_window: assert property (p_window) else $error("enable did not time out");
  property p_op_enable;
    @(posedge clk_sys_i) disable iff (!rstn_i) state_q == ST_OP |-> cmd_q[0];
  endproperty
  a_op_enable: assert property (p_op_enable) else $error("enable dropped during operation");
  property p_illegal;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_acc && !wr_legal && state_q == ST_IDLE |=> cmd_q == CMD_NONE && state_q == ST_IDLE;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal pattern armed");
  property p_abort;
    @(posedge clk_sys_i) disable iff (!rstn_i) arm_wr && wr_low == CMD_REEN |=> buf_valid_q == '0;
  endproperty
  a_abort: assert property (p_abort) else $error("load not aborted");
  property p_boot;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      strap_taken_q |-> boot_start_o == (boot_sz_q == 2'h3 ? BOOT_ST_128 : boot_sz_q == 2'h2 ? BOOT_ST_256 :
                                          boot_sz_q == 2'h1 ? BOOT_ST_512 : BOOT_ST_1K);
  endproperty
  a_boot: assert property (p_boot) else $error("boot start mismatch");
  property p_op_len;
    @(posedge clk_sys_i) disable iff (!rstn_i) $rose(state_q == ST_OP) |-> (state_q == ST_OP)[*8];
  endproperty
  a_op_len: assert property (p_op_len) else $error("operation ended too early");

  c_erase: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) prog_start_o && prog_erase_o);
  c_write: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) prog_start_o && !prog_erase_o);
  c_reen:  cover property (@(posedge clk_sys_i) disable iff (!rstn_i) store && cmd_q == CMD_REEN && busy_q);
  c_lpm:   cover property (@(posedge clk_sys_i) disable iff (!rstn_i) lpm_req_i && cmd_q == CMD_LOCK);

endmodule // fsp_ctrl

/* test/fsp_core_model.sv */
/*
  Core model: issues store and program-load pulses with pointer and register values.
  Assumes the bench calls its tasks in a process that runs right after a rising edge.
*/
module fsp_core_model (
  input  wire logic        clk_i,
  output logic             spm_req_o,
  output logic             lpm_req_o,
  output logic [15:0]      z_ptr_o,
  output logic [7:0]       r0_o,
  output logic [7:0]       r1_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle core: no requests
  initial begin
    {spm_req_o, lpm_req_o, z_ptr_o, r0_o, r1_o} = '0;
  end

  // One store pulse; lines toggle afterwards so stale values never look valid
  task automatic store(input logic [15:0] z, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i);
    spm_req_o <= 1'b1;
    z_ptr_o   <= {z[15:1], 1'b0};
    r0_o      <= a;
    r1_o      <= b;
    @(posedge clk_i);
    spm_req_o <= 1'b0;
    z_ptr_o   <= ~z;
    r0_o      <= ~a;
    r1_o      <= ~b;
  endtask

  // One program-load pulse; bit zero picks the byte
  task automatic load(input logic [15:0] z);
    @(posedge clk_i);
    lpm_req_o <= 1'b1;
    z_ptr_o   <= z;
    @(posedge clk_i);
    lpm_req_o <= 1'b0;
    z_ptr_o   <= ~z;
  endtask
endmodule  // fsp_core_model

/* test/tb_flash_self_program_control.sv */
/*
  Self-checking bench for the self-programming controller.
  Assumes fsp_pkg, the controller and the core model are compiled before it.
*/
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_flash_self_program_control;
  timeunit 1ns;
  timeprecision 100ps;
  import fsp_pkg::*;
  localparam int PC = 20;
  logic        clk_sys_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, gie_i;
  logic        spm, lpm, ready_irq_o, cpu_halt_o, region_blocked_o, lpm_valid_o, perase, pdone, pstart;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_readdata_o, avs_writedata_i, exp_v, zr;
  logic [15:0] z, bdata;
  logic [7:0]  r0, r1, fuse_bits_i, lpm_data_o, lock_bits_o;
  logic [12:0] boot_start_o;
  logic [12:0] starts[4] = '{BOOT_ST_1K, BOOT_ST_512, BOOT_ST_256, BOOT_ST_128};
  logic [6:0]  ppage;
  logic [5:0]  bidx;
  logic [1:0]  boot_size_select_i;
  logic [31:0] rd_q[$];
  logic [7:0]  ld_q[$];
  int          fails, samples_checked, cycles;
  integer      seed;

  fsp_ctrl #(.PROG_CYCLES(PC)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .spm_req_i(spm), .lpm_req_i(lpm), .z_ptr_i(z), .r0_i(r0), .r1_i(r1), .gie_i(gie_i),
    .boot_size_select_i(boot_size_select_i), .fuse_bits_i(fuse_bits_i), .ready_irq_o(ready_irq_o),
    .cpu_halt_o(cpu_halt_o), .region_blocked_o(region_blocked_o), .lpm_valid_o(lpm_valid_o),
    .lpm_data_o(lpm_data_o), .boot_start_o(boot_start_o), .lock_bits_o(lock_bits_o),
    .prog_start_o(pstart), .prog_erase_o(perase), .prog_page_o(ppage), .prog_done_o(pdone),
    .prog_buf_idx_i(bidx), .prog_buf_data_o(bdata));
  fsp_core_model core (.clk_i(clk_sys_i), .spm_req_o(spm), .lpm_req_o(lpm), .z_ptr_o(z), .r0_o(r0), .r1_o(r1));

  // Clock and hang guard
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // Watcher: oldest note against each read answer and each load answer
  always @(posedge clk_sys_i) begin
    if (avs_read_i && !avs_waitrequest_o) begin
      exp_v = rd_q.pop_front();
      `CHK("readdata", exp_v, avs_readdata_o)
    end
    if (lpm_valid_o) begin
      exp_v = {24'h0, ld_q.pop_front()};
      `CHK("lpm_data", exp_v[7:0], lpm_data_o)
    end
  end

  // Avalon transfer: hold until waitrequest seen low, then release
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] ex);
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= d;
    if (!w) rd_q.push_back(ex);
    @(posedge clk_sys_i);
    while (avs_waitrequest_o) @(posedge clk_sys_i);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic csr_wr(input logic [7:0] d);
    bus(1'b1, CSR_ADDR, {24'h0, d}, 32'h0);
  endtask
  task automatic csr_rd(input logic [7:0] ex);
    bus(1'b0, CSR_ADDR, 32'h0, {24'h0, ex});
  endtask
  task automatic wait_done();
    while (!pdone) @(posedge clk_sys_i);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    {clk_sys_i, rstn_i, avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, gie_i, bidx} = '0;
    {boot_size_select_i, fails, samples_checked, cycles} = '0;
    seed = 32'h1727c10e;
    zr = $random(seed);
    fuse_bits_i = zr[7:0];
    for (int i = 0; i < 4; i++) begin
      boot_size_select_i <= 2'(i);
      rstn_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      settle(2);
      `CHK("boot_start", starts[i], boot_start_o)
      @(posedge clk_sys_i);
    end
    `CHK("lock_bits", LOCK_RESET, lock_bits_o)
    csr_rd(CSR_RESET);
    bus(1'b0, CFG_ADDR, 32'h0, 32'h3);
    bus(1'b1, 10'h100, 32'hff, 32'h0);
    bus(1'b0, 10'h100, 32'h0, 32'h0);
    foreach (starts[i]) begin
      csr_wr(8'h20 | (8'h07 << i));
      csr_rd(8'h00);
    end
    gie_i <= 1'b1;
    csr_wr(8'h80);
    settle(2);
    `CHK("irq", 1'b1, ready_irq_o)
    csr_wr(8'h81);
    settle(1);
    `CHK("irq", 1'b0, ready_irq_o)
    settle(6);
    `CHK("irq", 1'b1, ready_irq_o)
    csr_rd(8'h80);
    csr_wr(8'h00);
    zr = $random(seed);
    csr_wr(CMD_FILL);
    csr_wr(CMD_FILL);
    core.store({zr[31:30], 7'd9, zr[21:16], 1'b0}, zr[7:0], zr[15:8]);
    csr_rd(8'h00);
    @(posedge clk_sys_i);
    bidx <= zr[21:16];
    settle(2);
    `CHK("buffer", zr[15:0], bdata)
    csr_wr(CMD_ERASE);
    core.store({2'b00, 7'd5, 6'd0, 1'b0}, 8'h00, 8'h00);
    settle(0);
    `CHK("start", 1'b1, pstart)
    csr_rd(8'h43);
    `CHK("page", 7'd5, ppage)
    `CHK("erase", 1'b1, perase)
    csr_wr(CMD_REEN);
    core.store(16'h0000, 8'h00, 8'h00);
    settle(0);
    `CHK("blocked", 1'b1, region_blocked_o)
    wait_done();
    csr_rd(8'h40);
    csr_wr(CMD_REEN);
    core.store(16'h0000, 8'h00, 8'h00);
    csr_rd(8'h00);
    csr_wr(CMD_ERASE);
    core.store({2'b00, 7'd112, 6'd0, 1'b0}, 8'h00, 8'h00);
    settle(1);
    `CHK("halt", 1'b1, cpu_halt_o)
    `CHK("blocked", 1'b0, region_blocked_o)
    bus(1'b0, CFG_ADDR, 32'h0, 32'hf);
    wait_done();
    settle(1);
    `CHK("halt", 1'b0, cpu_halt_o)
    csr_wr(CMD_WRITE);
    core.store({2'b00, 7'd111, 6'd0, 1'b0}, zr[7:0], zr[15:8]);
    settle(1);
    `CHK("page", 7'd111, ppage)
    `CHK("erase", 1'b0, perase)
    `CHK("halt", 1'b0, cpu_halt_o)
    `CHK("blocked", 1'b1, region_blocked_o)
    wait_done();
    csr_rd(8'h40);
    csr_wr(CMD_FILL);
    core.store(16'h0002, 8'h00, 8'h00);
    csr_rd(8'h00);
    csr_wr(CMD_LOCK);
    ld_q.push_back(LOCK_RESET);
    core.load(16'h0000);
    core.store(~zr[15:0], zr[23:16], zr[31:24]);
    csr_rd(8'h09);
    settle(PC + 4);
    csr_rd(8'h00);
    `CHK("lock_bits", zr[23:16], lock_bits_o)
    csr_wr(CMD_LOCK);
    ld_q.push_back(fuse_bits_i);
    core.load(16'h0001);
    settle(6);
    csr_rd(8'h00);
    ld_q.push_back(8'h00);
    core.load(16'h0001);
    settle(2);
    report_and_stop();
  end
endmodule  // tb_flash_self_program_control
